// File: core/ep_fifo_cfg_pkg.sv
// constants for the endpoint fifo configuration register bank
package ep_fifo_cfg_pkg;

    // byte offsets on the avalon bus, one 32-bit word each
    localparam logic [5:0] OFS_INPUT_FIFO_ENABLE = 6'h00;
    localparam logic [5:0] OFS_SIZE_SELECT_LOW   = 6'h04;
    localparam logic [5:0] OFS_SIZE_SELECT_HIGH  = 6'h08;
    localparam logic [5:0] OFS_ACCESS_CONTROL    = 6'h0c;
    localparam logic [5:0] OFS_DATA_PORT_BASE    = 6'h20;

    // field positions
    localparam int RECONFIG_BIT     = 0;
    localparam int LOW_SEL_BASE_BIT = 2;
    localparam int CTRL_REQUEST_BIT = 0;
    localparam int CTRL_DIR_BIT     = 1;
    localparam int CTRL_READY_BIT   = 2;

    // reset values
    localparam logic [7:0] INPUT_FIFO_ENABLE_RST = 8'h00;
    localparam logic [7:0] SIZE_SELECT_RST       = 8'h00;
    localparam logic [7:0] ACCESS_CONTROL_RST    = 8'h00;

    // fifo depth encoding of a size selector
    localparam logic [1:0] SIZE_SEL_8  = 2'h0;
    localparam logic [1:0] SIZE_SEL_16 = 2'h1;
    localparam logic [1:0] SIZE_SEL_32 = 2'h2;
    localparam logic [1:0] SIZE_SEL_64 = 2'h3;

endpackage

// File: core/ep_size_decode.sv
// decodes a 2-bit endpoint size selector into a fifo depth in bytes
`timescale 1ns/1ps

module ep_size_decode (
    input  wire logic [1:0] size_sel,   // selector from the size register
    output logic      [6:0] depth_bytes // fifo depth, 8 to 64
);

    always_comb begin
        case (size_sel)
            ep_fifo_cfg_pkg::SIZE_SEL_8:  depth_bytes = 7'h08;
            ep_fifo_cfg_pkg::SIZE_SEL_16: depth_bytes = 7'h10;
            ep_fifo_cfg_pkg::SIZE_SEL_32: depth_bytes = 7'h20;
            default:                      depth_bytes = 7'h40;
        endcase
    end

endmodule

// File: core/usb_endpoint_fifo_config_regs.sv
// register bank for endpoint fifo enables, sizes and data ports
`timescale 1ns/1ps

module usb_endpoint_fifo_config_regs #(
    parameter int EP_COUNT = 7              // non-control endpoints: 3, 5 or 7
) (
    input  wire logic        sys_clk,          // 200 mhz clock
    input  wire logic        sys_rst,          // asynchronous reset, active high
    input  wire logic [5:0]  avs_address,      // byte address
    input  wire logic        avs_read,         // read request
    input  wire logic        avs_write,        // write request
    input  wire logic [31:0] avs_writedata,    // write data
    input  wire logic [3:0]  avs_byteenable,   // byte lanes
    output logic      [31:0] avs_readdata,     // read data
    output logic             avs_waitrequest,  // stall
    output logic      [7:0]  in_fifo_enable,   // input fifo enables, bit n for endpoint n
    output logic             reconfig_request, // rebuild request level
    input  wire logic        reconfig_done,    // engine finished the rebuild, one-cycle pulse
    output logic      [15:0] size_select,      // selectors, endpoint n in bits 2n+1:2n
    output logic      [55:0] fifo_depth,       // decoded depth, endpoint n in bits 8n-2:8n-8
    output logic      [2:0]  fifo_select,      // endpoint chosen for access
    output logic             fifo_request,     // access request flag
    output logic             fifo_write_dir,   // 1 while software writes the fifo
    input  wire logic        fifo_ready,       // engine grants the selected fifo
    output logic      [7:0]  fifo_wr_data,     // byte written to a data port
    output logic             fifo_wr_strobe,   // one-cycle pulse per data write
    output logic      [2:0]  fifo_wr_ep,       // endpoint of that write
    input  wire logic [7:0]  fifo_rd_data,     // byte the engine offers for reads
    output logic             fifo_rd_strobe,   // one-cycle pulse per data read
    output logic      [2:0]  fifo_rd_ep        // endpoint of that read
);

    ////////////////////////////////////////////////////////////////////////////////
    // state

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } bus_state_type;

    typedef struct packed {
        bus_state_type bus;
        logic [7:0]    enable;
        logic [15:0]   sizes;
        logic [2:0]    sel;
        logic          req;
        logic          dir;
        logic [31:0]   rdata;
        logic [7:0]    wdata;
        logic          wstb;
        logic [2:0]    wep;
        logic          rstb;
        logic [2:0]    rep;
    } state_type;

    state_type state_r;
    state_type state_nxt;
    logic      ready_s1_r;
    logic      ready_s2_r;

    // mask of implemented enable bits, bit 0 is the rebuild request
    localparam logic [7:0] ENABLE_MASK = 8'((16'h1 << (EP_COUNT + 1)) - 16'h1);
    // selectors for endpoint 1..EP_COUNT in the packed size word
    localparam logic [15:0] SIZE_MASK = 16'(((32'h1 << (2 * EP_COUNT)) - 32'h1) << 2);

    function automatic logic [7:0] merge_byte(input logic [7:0] old_v, input logic [7:0] new_v,
                                              input logic lane, input logic [7:0] mask);
        merge_byte = lane ? ((old_v & ~mask) | (new_v & mask)) : old_v;
    endfunction

    function automatic logic is_data_port(input logic [5:0] addr);
        is_data_port = (addr >= ep_fifo_cfg_pkg::OFS_DATA_PORT_BASE) && (addr[1:0] == 2'h0)
                       && (addr[4:2] <= 3'(EP_COUNT));
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // register and bus logic

    always_comb begin
        logic [7:0]  low_v;
        logic [7:0]  high_v;
        logic [7:0]  rbyte;
        logic        wr;
        logic        rd;
        logic [15:0] sz_new;
        low_v     = '0;
        high_v    = '0;
        rbyte     = '0;
        sz_new    = state_r.sizes;
        state_nxt = state_r;
        wr        = avs_write && (state_r.bus == BUS_IDLE);
        rd        = avs_read && (state_r.bus == BUS_IDLE);
        state_nxt.wstb = 1'b0;
        state_nxt.rstb = 1'b0;
        // low register view: endpoints 1..3 at bits 3:2, 5:4, 7:6
        low_v  = {state_r.sizes[7:2], 2'h0};
        // high register view: endpoints 4..7 at bits 1:0 upward
        high_v = state_r.sizes[15:8];

        // hardware clears the rebuild request once the engine is done
        if (reconfig_done) begin
            state_nxt.enable[ep_fifo_cfg_pkg::RECONFIG_BIT] = 1'b0;
        end

        case (state_r.bus)
            BUS_IDLE: begin
                if (wr || rd) begin
                    state_nxt.bus = BUS_ACK;
                end
            end
            BUS_ACK: begin
                state_nxt.bus = BUS_IDLE;
            end
            default: begin
                state_nxt.bus = BUS_IDLE;
            end
        endcase

        if (wr) begin
            if (avs_address == ep_fifo_cfg_pkg::OFS_INPUT_FIFO_ENABLE) begin
                // write enables and rebuild request, unbuilt bits dropped
                // merging onto the already cleared value keeps a done pulse when lane 0 is off
                state_nxt.enable = merge_byte(state_nxt.enable, avs_writedata[7:0], avs_byteenable[0],
                                              ENABLE_MASK);
            end else if (avs_address == ep_fifo_cfg_pkg::OFS_SIZE_SELECT_LOW) begin
                sz_new[7:0] = merge_byte(state_r.sizes[7:0], avs_writedata[7:0], avs_byteenable[0],
                                         SIZE_MASK[7:0]);
            end else if (avs_address == ep_fifo_cfg_pkg::OFS_SIZE_SELECT_HIGH) begin
                sz_new[15:8] = merge_byte(state_r.sizes[15:8], avs_writedata[7:0], avs_byteenable[0],
                                          SIZE_MASK[15:8]);
            end else if (avs_address == ep_fifo_cfg_pkg::OFS_ACCESS_CONTROL) begin
                if (avs_byteenable[0]) begin
                    // request and direction flags written by software
                    state_nxt.req = avs_writedata[ep_fifo_cfg_pkg::CTRL_REQUEST_BIT];
                    state_nxt.dir = avs_writedata[ep_fifo_cfg_pkg::CTRL_DIR_BIT];
                end
                if (avs_byteenable[1]) begin
                    state_nxt.sel = avs_writedata[10:8];
                end
            end else if (is_data_port(avs_address)) begin
                // byte write to an endpoint data port
                if (avs_byteenable[0]) begin
                    state_nxt.wdata = avs_writedata[7:0];
                    state_nxt.wstb  = 1'b1;
                    state_nxt.wep   = avs_address[4:2];
                end
            end
            // size selectors of absent endpoints stay zero
            state_nxt.sizes = sz_new & SIZE_MASK;
        end

        if (rd) begin
            if (avs_address == ep_fifo_cfg_pkg::OFS_INPUT_FIFO_ENABLE) begin
                rbyte = state_r.enable;
            end else if (avs_address == ep_fifo_cfg_pkg::OFS_SIZE_SELECT_LOW) begin
                rbyte = low_v;
            end else if (avs_address == ep_fifo_cfg_pkg::OFS_SIZE_SELECT_HIGH) begin
                rbyte = high_v;
            end else if (avs_address == ep_fifo_cfg_pkg::OFS_ACCESS_CONTROL) begin
                rbyte = {5'h00, ready_s2_r, state_r.dir, state_r.req};
            end else if (is_data_port(avs_address)) begin
                // byte read from an endpoint data port
                rbyte = fifo_rd_data;
                state_nxt.rstb = 1'b1;
                state_nxt.rep  = avs_address[4:2];
            end
            // upper bits and unmapped addresses read zero
            state_nxt.rdata = {24'h000000, rbyte};
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            // all controls and selectors clear at reset
            state_r        <= '0;
            state_r.bus    <= BUS_IDLE;
            state_r.enable <= ep_fifo_cfg_pkg::INPUT_FIFO_ENABLE_RST;
            state_r.sizes  <= {ep_fifo_cfg_pkg::SIZE_SELECT_RST, ep_fifo_cfg_pkg::SIZE_SELECT_RST};
            ready_s1_r     <= 1'b0;
            ready_s2_r     <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            ready_s1_r <= fifo_ready;
            ready_s2_r <= ready_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign avs_waitrequest  = (avs_read || avs_write) && (state_r.bus != BUS_ACK);
    assign avs_readdata     = state_r.rdata;
    assign in_fifo_enable   = {state_r.enable[7:1], 1'b0};
    assign reconfig_request = state_r.enable[ep_fifo_cfg_pkg::RECONFIG_BIT];
    assign size_select      = state_r.sizes;
    assign fifo_select      = state_r.sel;
    assign fifo_request     = state_r.req;
    assign fifo_write_dir   = state_r.dir;
    assign fifo_wr_data     = state_r.wdata;
    assign fifo_wr_strobe   = state_r.wstb;
    assign fifo_wr_ep       = state_r.wep;
    assign fifo_rd_strobe   = state_r.rstb;
    assign fifo_rd_ep       = state_r.rep;

    // decode each selector into a depth, endpoint n in byte n-1
    for (genvar n = 1; n < 8; n++) begin : g_depth
        ep_size_decode u_dec (
            .size_sel    (state_r.sizes[2*n+1:2*n]),
            .depth_bytes (fifo_depth[8*n-2:8*n-8])
        );
        assign fifo_depth[8*n-1] = 1'b0;
    end

endmodule

// File: test/usb_endpoint_fifo_config_regs_checker.sv
// bus timing, rebuild request and data port checks for the register bank
`timescale 1ns/1ps
module ep_cfg_checker #(
    parameter int EP_COUNT = 7 // endpoints built
) (
    input wire logic        sys_clk,         // clock
    input wire logic        sys_rst,         // reset
    input wire logic [5:0]  avs_address,     // address
    input wire logic        avs_read,        // read
    input wire logic        avs_write,       // write
    input wire logic [31:0] avs_writedata,   // write data
    input wire logic [3:0]  avs_byteenable,  // lanes
    input wire logic [31:0] avs_readdata,    // read data
    input wire logic        avs_waitrequest, // stall
    input wire logic [7:0]  in_fifo_enable,  // enables
    input wire logic        reconfig_request, // rebuild
    input wire logic        reconfig_done,   // rebuild done
    input wire logic [15:0] size_select,     // selectors
    input wire logic [55:0] fifo_depth,      // depths
    input wire logic [7:0]  fifo_wr_data,    // pushed byte
    input wire logic        fifo_wr_strobe,  // push
    input wire logic [7:0]  fifo_rd_data,    // offered byte
    input wire logic        fifo_rd_strobe   // pop
);
    localparam logic [7:0]  EN_MASK = 8'((1 << (EP_COUNT + 1)) - 2);
    localparam logic [15:0] SZ_MASK = 16'((1 << (2 * EP_COUNT + 2)) - 4);
    logic dport;
    assign dport = avs_address >= 6'h20 && avs_address[1:0] == 2'h0
                   && {1'b0, avs_address} < 7'(32 + 4 * (EP_COUNT + 1));
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    sequence en_wr_s;
        avs_write && avs_waitrequest && avs_address == 6'h00 && avs_byteenable[0];
    endsequence
    sequence data_wr_s;
        avs_write && avs_waitrequest && dport && avs_byteenable[0];
    endsequence
    sequence data_rd_s;
        avs_read && avs_waitrequest && dport;
    endsequence
    sequence push_one_s;
        fifo_wr_strobe && fifo_wr_data == $past(avs_writedata[7:0]) ##1 !fifo_wr_strobe;
    endsequence
    sequence pop_one_s;
        fifo_rd_strobe && avs_readdata == {24'h000000, $past(fifo_rd_data)};
    endsequence
    one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer not after one wait cycle");
    set_req_a: assert property (en_wr_s ##0 avs_writedata[0] |=> reconfig_request)
        else $error("rebuild request not set");
    clear_done_a: assert property (reconfig_done && !(avs_write && avs_address == 6'h00) |=> !reconfig_request)
        else $error("rebuild request not cleared");
    en_bits_a: assert property (en_wr_s |=> in_fifo_enable == ($past(avs_writedata[7:0]) & EN_MASK))
        else $error("enable bits differ from write");
    unused_zero_a: assert property ((in_fifo_enable & ~EN_MASK) == 8'h00 && (size_select & ~SZ_MASK) == 16'h0000)
        else $error("unimplemented bit set");
    depth_map_a: assert property (fifo_depth[6:0] == 7'h08 << size_select[3:2])
        else $error("depth decode wrong");
    depth_high_a: assert property (fifo_depth[54:48] == 7'h08 << size_select[15:14])
        else $error("high endpoint depth decode wrong");
    push_pulse_a: assert property (data_wr_s |=> push_one_s)
        else $error("data port write pulse wrong");
    pop_data_a: assert property (data_rd_s |=> pop_one_s)
        else $error("data port read wrong");
endmodule
bind usb_endpoint_fifo_config_regs ep_cfg_checker #(.EP_COUNT(EP_COUNT)) chk_u (.sys_clk, .sys_rst, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .in_fifo_enable,
    .reconfig_request, .reconfig_done, .size_select, .fifo_depth, .fifo_wr_data, .fifo_wr_strobe, .fifo_rd_data,
    .fifo_rd_strobe);

// File: test/usb_endpoint_fifo_config_regs_test.sv
// self-checking bench driving the register bank over its avalon port
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, a, b); end end
module usb_endpoint_fifo_config_regs_test;
    logic sys_clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, reconfig_done = 1'b0, fifo_ready = 1'b0;
    logic [5:0]  avs_address = 6'h00;
    logic [31:0] avs_writedata = 32'h00000000, avs_readdata, q;
    logic [3:0]  avs_byteenable = 4'hf;
    logic [7:0]  fifo_rd_data = 8'h00, in_fifo_enable, fifo_wr_data;
    logic [15:0] size_select;
    logic [55:0] fifo_depth;
    logic [2:0]  fifo_select, fifo_wr_ep, fifo_rd_ep;
    logic        avs_waitrequest, reconfig_request, fifo_request, fifo_write_dir, fifo_wr_strobe, fifo_rd_strobe;
    int          error_cnt = 0, checks_done = 0;
    usb_endpoint_fifo_config_regs #(.EP_COUNT(7)) dut_u (.sys_clk, .sys_rst, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .in_fifo_enable, .reconfig_request,
        .reconfig_done, .size_select, .fifo_depth, .fifo_select, .fifo_request, .fifo_write_dir, .fifo_ready,
        .fifo_wr_data, .fifo_wr_strobe, .fifo_wr_ep, .fifo_rd_data, .fifo_rd_strobe, .fifo_rd_ep);
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    task conclude;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // one avalon transfer; returns at the rising edge that completes it
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge sys_clk);
        end while (avs_waitrequest !== 1'b0);
        r = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    initial begin
        repeat (2000) @(posedge sys_clk);
        error_cnt++;
        conclude();
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, 6'(4 * i), 32'h0, q);
            `CHK(q, 32'h00000000)
        end
        $display("reset values done");
        bus(1'b1, 6'h00, 32'h000000ff, q);
        `CHK(in_fifo_enable, 8'hfe)
        `CHK(reconfig_request, 1'b1)
        bus(1'b0, 6'h00, 32'h0, q);
        `CHK(q, 32'h000000ff)
        @(posedge sys_clk) reconfig_done <= 1'b1;
        @(posedge sys_clk) reconfig_done <= 1'b0;
        @(negedge sys_clk);
        `CHK(reconfig_request, 1'b0)
        bus(1'b0, 6'h00, 32'h0, q);
        `CHK(q, 32'h000000fe)
        $display("enable test done");
        for (int c = 0; c < 4; c++) begin
            bus(1'b1, 6'h04, 32'(8'h55 * c), q);
            `CHK(fifo_depth[6:0], 7'h08 << c)
            bus(1'b0, 6'h04, 32'h0, q);
            `CHK(q, 32'(8'h54 * c))
        end
        bus(1'b1, 6'h08, 32'hffffff1b, q);
        `CHK(size_select[15:8], 8'h1b)
        `CHK(fifo_depth[30:24], 7'h40)
        `CHK(fifo_depth[54:48], 7'h08)
        $display("size test done");
        bus(1'b1, 6'h10, 32'h000000ff, q);
        bus(1'b0, 6'h10, 32'h0, q);
        `CHK(q, 32'h00000000)
        bus(1'b1, 6'h2c, 32'h000000a5, q);
        `CHK(fifo_wr_data, 8'ha5)
        `CHK(fifo_wr_ep, 3'h3)
        @(posedge sys_clk) fifo_rd_data <= 8'h5a;
        bus(1'b0, 6'h24, 32'h0, q);
        `CHK(q, 32'h0000005a)
        `CHK(fifo_rd_ep, 3'h1)
        $display("data port test done");
        @(posedge sys_clk) fifo_ready <= 1'b1;
        bus(1'b1, 6'h0c, 32'h00000303, q);
        `CHK({fifo_select, fifo_request}, 4'h7)
        `CHK(fifo_write_dir, 1'b1)
        repeat (3) @(posedge sys_clk);
        bus(1'b0, 6'h0c, 32'h0, q);
        `CHK(q, 32'h00000007)
        bus(1'b1, 6'h0c, 32'h00000301, q);
        `CHK(fifo_write_dir, 1'b0)
        bus(1'b1, 6'h0c, 32'h00000000, q);
        `CHK(fifo_request, 1'b0)
        $display("access test done");
        conclude();
    end
endmodule
